// ==== pkg/ebct_pkg.sv ====
// Constants and types shared by the dual 8-bit compare timer.
// Assumes a single system clock and a CPU special-function-register port.
package ebct_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] TA_BASE   = 8'hCA;
    localparam logic [7:0] TB_BASE   = 8'hEA;
    localparam logic [7:0] OFS_CNT   = 8'h00;
    localparam logic [7:0] OFS_CTL   = 8'h01;
    localparam logic [7:0] OFS_CCTL0 = 8'h02;
    localparam logic [7:0] OFS_CC0   = 8'h03;
    localparam logic [7:0] OFS_CCTL1 = 8'h04;
    localparam logic [7:0] OFS_CC1   = 8'h05;
    localparam logic [7:0] FLAG_ADDR = 8'hD8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_DIV_LSB  = 5;
    localparam int CTL_START    = 4;
    localparam int CTL_TERMINAL_COUNT_IRQ_MASK    = 3;
    localparam int CTL_CLR      = 2;
    localparam int CCTL_IM      = 6;
    localparam int CCTL_CMP_LSB = 3;
    localparam int CCTL_OC      = 2;
    localparam int FLG_STRIDE   = 3;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [7:0] CNT_ZERO  = 8'h00;
    localparam logic [7:0] CNT_TERM  = 8'hFF;
    localparam logic [7:0] CNT_ONE   = 8'h01;
    localparam logic [6:0] PRE_ONE   = 7'h01;

    typedef enum logic [1:0] {
        EBCT_FREE = 2'h0,
        EBCT_DOWN = 2'h1,
        EBCT_MOD  = 2'h2,
        EBCT_UPDN = 2'h3
    } ebct_mode_t;

    localparam logic [2:0] ACT_SET    = 3'h0;
    localparam logic [2:0] ACT_CLR    = 3'h1;
    localparam logic [2:0] ACT_TGL    = 3'h2;
    localparam logic [2:0] ACT_SET_UP = 3'h3;
    localparam logic [2:0] ACT_CLR_UP = 3'h4;

    typedef struct packed {
        logic [7:0] cnt;
        logic [6:0] presc;
        logic [2:0] div;
        logic       start;
        logic       terminal_count_irq_mask;
        ebct_mode_t mode;
        logic [7:0] cc0_buf;
        logic [7:0] cc0_act;
        logic [7:0] cc1;
        logic [1:0] im;
        logic [5:0] cmp;
        logic [1:0] oc;
        logic       dir_down;
        logic       moved_down;
        logic       upd;
        logic       armed;
        logic [2:0] flags;
        logic       cpu_flag;
        logic       irq;
    } ebct_timer_t;

    localparam ebct_timer_t TMR_RST = '{
        terminal_count_irq_mask: 1'b1, im: 2'h3, mode: EBCT_FREE, default: '0};

endpackage

// ==== rtl/ebct_chan.sv ====
// One compare channel: match detection and the registered output pin.
// Assumes count and upd come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ebct_chan
    import ebct_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Counter view
    input  wire logic       upd,
    input  wire logic [7:0] count,
    input  wire logic       moved_down,
    input  wire logic       updown,
    // Channel setup
    input  wire logic [7:0] cmp_value,
    input  wire logic [2:0] action,
    input  wire logic       enable,
    // Results
    output logic            hit,
    output logic            pin
);

    typedef struct packed {
        logic hit;
        logic pin;
    } ebct_chan_t;

    ebct_chan_t st;
    ebct_chan_t next_st;

    // ------------------------------------------------------------------
    // Compare and action
    // ------------------------------------------------------------------
    always_comb
    begin
        logic match;
        logic zero;
        logic back;
        match = upd && (count == cmp_value);
        zero  = upd && (count == CNT_ZERO);
        // Second edge of modes 3/4 moves to compare-down when centred
        back  = updown ? (match && moved_down) : zero;
        next_st     = st;
        next_st.hit = match;
        if (enable)
        begin
            case (action)
                ACT_SET:    if (match) next_st.pin = 1'b1;
                ACT_CLR:    if (match) next_st.pin = 1'b0;
                ACT_TGL:    if (match) next_st.pin = ~st.pin;
                ACT_SET_UP:
                begin
                    if (match && !moved_down)
                        next_st.pin = 1'b1;
                    else if (back)
                        next_st.pin = 1'b0;
                end
                ACT_CLR_UP:
                begin
                    if (match && !moved_down)
                        next_st.pin = 1'b0;
                    else if (back)
                        next_st.pin = 1'b1;
                end
                default: next_st.pin = st.pin;
            endcase
        end
    end

    // Pin driven only from a flop so edges cannot glitch
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign hit = st.hit;
    assign pin = st.pin;

endmodule
`default_nettype wire

// ==== rtl/ebct_top.sv ====
// Two 8-bit compare timers behind the CPU special-function-register port.
// Assumes timer_tick is a one-cycle pulse on the same clock, and the
// interrupt enables come from the CPU interrupt controller.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Modulo mode counts up from zero
// - Modulo wraps after compare zero, flags terminal
// - CPU flag and request gated by masks
// - Down mode loads compare, counts, holds zero
// - Down mode flags terminal at zero
// - Up/down counts up to compare, back down
// - Up/down flags terminal on reaching zero
// - Compare sets, clears or toggles channel pin
// - Channel pin edges are glitch free
// - Channel zero compare loads at zero count
// - Channel one compare takes effect at once
// - Match sets channel flag, mask gates CPU
// - Up/down channel zero flags at zero
// - Event flags set regardless of masks
// - Unmasking a set flag requests at once
// - One request line per timer
// - Each channel match pulses DMA trigger
// - Counter value readable, resets to zero
// - Prescaler divides by power of two
// - Mode field picks four counting modes
// - Start bit runs, zero halts counter
// - Compare action codes and up/down variant
module ebct_top
    import ebct_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Timer tick
    input  wire logic       timer_tick,
    // Special-function-register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Interrupts
    input  wire logic [1:0] timer_interrupt_enable,
    output logic      [1:0] cpu_timer_interrupt_flag,
    output logic      [1:0] timer_irq,
    // DMA triggers
    output logic            dma_trig_a_chan0,
    output logic            dma_trig_a_chan1,
    output logic            dma_trig_b_chan0,
    output logic            dma_trig_b_chan1,
    // Channel pins
    output logic      [3:0] chan_out,
    output logic      [3:0] chan_oe
);

    typedef struct packed {
        ebct_timer_t [1:0] tmr;
        logic [7:0]        rdata;
    } ebct_state_t;

    ebct_state_t st;
    ebct_state_t next_st;
    logic [3:0]  hit;
    logic [1:0]  act;

    function automatic logic [7:0] addr_of(input int t,
                                           input logic [7:0] ofs);
        addr_of = (t == 0) ? (TA_BASE + ofs) : (TB_BASE + ofs);
    endfunction

    function automatic logic presc_hit(input logic [6:0] presc,
                                       input logic [2:0] div);
        logic [6:0] mask;
        mask = 7'((8'h01 << div) - 8'h01);
        presc_hit = ((presc & mask) == mask);
    endfunction

    // ------------------------------------------------------------------
    // Active edges
    // ------------------------------------------------------------------
    // Mask is read live, so a divider change acts on the next tick
    assign act[0] = st.tmr[0].start && timer_tick
                    && presc_hit(st.tmr[0].presc, st.tmr[0].div);
    assign act[1] = st.tmr[1].start && timer_tick
                    && presc_hit(st.tmr[1].presc, st.tmr[1].div);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        ebct_timer_t c;
        ebct_timer_t n;
        logic        ovf;
        logic        ch0;
        logic        ch1;
        logic [7:0]  r;
        c   = '0;
        n   = '0;
        ovf = 1'b0;
        ch0 = 1'b0;
        ch1 = 1'b0;
        r   = 8'h00;
        next_st = st;
        for (int t = 0; t < 2; t++)
        begin
            c = st.tmr[t];
            n = c;
            n.upd = 1'b0;
            if (c.start && timer_tick)
                n.presc = 7'(c.presc + PRE_ONE);
            if (c.cnt == CNT_ZERO)
                n.cc0_act = c.cc0_buf;
            if (act[t])
            begin
                n.upd        = 1'b1;
                n.moved_down = 1'b0;
                n.armed      = 1'b0;
                case (c.mode)
                    EBCT_FREE:
                        n.cnt = (c.cnt == CNT_TERM) ? CNT_ZERO
                                : 8'(c.cnt + CNT_ONE);
                    EBCT_MOD:
                        n.cnt = (c.cnt == c.cc0_act) ? CNT_ZERO
                                : 8'(c.cnt + CNT_ONE);
                    EBCT_DOWN:
                    begin
                        if (c.armed)
                            n.cnt = c.cc0_buf;
                        else if (c.cnt != CNT_ZERO)
                        begin
                            n.cnt        = 8'(c.cnt - CNT_ONE);
                            n.moved_down = 1'b1;
                        end
                        else
                            n.upd = 1'b0;
                    end
                    EBCT_UPDN:
                    begin
                        if (!c.dir_down)
                        begin
                            if (c.cnt == c.cc0_act)
                            begin
                                // A zero period sits at zero instead
                                n.dir_down   = (c.cnt != CNT_ZERO);
                                n.moved_down = n.dir_down;
                                n.cnt        = n.dir_down
                                               ? 8'(c.cnt - CNT_ONE)
                                               : CNT_ZERO;
                            end
                            else
                                n.cnt = 8'(c.cnt + CNT_ONE);
                        end
                        else if (c.cnt == CNT_ZERO)
                        begin
                            n.dir_down = 1'b0;
                            n.cnt      = CNT_ONE;
                        end
                        else
                        begin
                            n.cnt        = 8'(c.cnt - CNT_ONE);
                            n.moved_down = 1'b1;
                        end
                    end
                    default: n.cnt = c.cnt;
                endcase
            end
            // Register writes
            if (sfr_wr && sfr_addr == addr_of(t, OFS_CTL))
            begin
                n.div   = sfr_wdata[CTL_DIV_LSB +: 3];
                n.start = sfr_wdata[CTL_START];
                n.terminal_count_irq_mask = sfr_wdata[CTL_TERMINAL_COUNT_IRQ_MASK];
                n.mode  = ebct_mode_t'(sfr_wdata[1:0]);
                if (sfr_wdata[CTL_START] && !c.start)
                    n.armed = 1'b1;
                if (sfr_wdata[CTL_CLR])
                begin
                    n.cnt      = CNT_ZERO;
                    n.dir_down = 1'b0;
                    n.upd      = 1'b0;
                end
            end
            if (sfr_wr && sfr_addr == addr_of(t, OFS_CCTL0))
            begin
                n.im[0]    = sfr_wdata[CCTL_IM];
                n.cmp[2:0] = sfr_wdata[CCTL_CMP_LSB +: 3];
                n.oc[0]    = sfr_wdata[CCTL_OC];
            end
            if (sfr_wr && sfr_addr == addr_of(t, OFS_CCTL1))
            begin
                n.im[1]    = sfr_wdata[CCTL_IM];
                n.cmp[5:3] = sfr_wdata[CCTL_CMP_LSB +: 3];
                n.oc[1]    = sfr_wdata[CCTL_OC];
            end
            if (sfr_wr && sfr_addr == addr_of(t, OFS_CC0))
                n.cc0_buf = sfr_wdata;
            if (sfr_wr && sfr_addr == addr_of(t, OFS_CC1))
                n.cc1 = sfr_wdata;
            // Events
            case (c.mode)
                EBCT_FREE: ovf = c.upd && (c.cnt == CNT_TERM);
                EBCT_MOD:  ovf = c.upd && (c.cnt == c.cc0_act);
                default:   ovf = c.upd && (c.cnt == CNT_ZERO)
                                 && c.moved_down;
            endcase
            ch0 = (c.mode == EBCT_UPDN) ? ovf : hit[2*t];
            ch1 = hit[2*t+1];
            if (sfr_wr && sfr_addr == FLAG_ADDR)
                n.flags = c.flags & sfr_wdata[FLG_STRIDE*t +: 3];
            // Set after the clear so a same-cycle event survives
            n.flags = n.flags | {ch1, ch0, ovf};
            n.cpu_flag = |(c.flags & {c.im[1], c.im[0], c.terminal_count_irq_mask});
            n.irq = c.cpu_flag && timer_interrupt_enable[t];
            next_st.tmr[t] = n;
        end
        // Read mux, unmapped addresses read zero
        for (int t = 0; t < 2; t++)
        begin
            c = st.tmr[t];
            if (sfr_addr == addr_of(t, OFS_CNT))
                r = c.cnt;
            if (sfr_addr == addr_of(t, OFS_CTL))
                r = {c.div, c.start, c.terminal_count_irq_mask, 1'b0, c.mode};
            if (sfr_addr == addr_of(t, OFS_CCTL0))
                r = {1'b0, c.im[0], c.cmp[2:0], c.oc[0], 2'h0};
            if (sfr_addr == addr_of(t, OFS_CCTL1))
                r = {1'b0, c.im[1], c.cmp[5:3], c.oc[1], 2'h0};
            if (sfr_addr == addr_of(t, OFS_CC0))
                r = c.cc0_buf;
            if (sfr_addr == addr_of(t, OFS_CC1))
                r = c.cc1;
        end
        if (sfr_addr == FLAG_ADDR)
            r = {2'h0, st.tmr[1].flags, st.tmr[0].flags};
        next_st.rdata = r;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            st.tmr[0] <= TMR_RST;
            st.tmr[1] <= TMR_RST;
            st.rdata  <= 8'h00;
        end
        else
            st <= next_st;
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 4; g++)
    begin : g_chan
        localparam int T = g / 2;
        localparam int K = g % 2;
        ebct_chan u_chan (
            .clock      (clock),
            .resetn     (resetn),
            .upd        (st.tmr[T].upd),
            .count      (st.tmr[T].cnt),
            .moved_down (st.tmr[T].moved_down),
            .updown     (st.tmr[T].mode == EBCT_UPDN),
            .cmp_value  ((K == 0) ? st.tmr[T].cc0_act : st.tmr[T].cc1),
            .action     (st.tmr[T].cmp[3*K +: 3]),
            .enable     (st.tmr[T].oc[K]),
            .hit        (hit[g]),
            .pin        (chan_out[g])
        );
    end

    assign sfr_rdata                = st.rdata;
    assign cpu_timer_interrupt_flag = {st.tmr[1].cpu_flag,
                                       st.tmr[0].cpu_flag};
    assign timer_irq                = {st.tmr[1].irq, st.tmr[0].irq};
    assign dma_trig_a_chan0         = hit[0];
    assign dma_trig_a_chan1         = hit[1];
    assign dma_trig_b_chan0         = hit[2];
    assign dma_trig_b_chan1         = hit[3];
    assign chan_oe                  = {st.tmr[1].oc, st.tmr[0].oc};

    // ------------------------------------------------------------------
    // Checks on timer A
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_ctl_quiet;
        !(sfr_wr && sfr_addr == TA_BASE + OFS_CTL);
    endsequence

    sequence s_mod_step;
        act[0] && st.tmr[0].mode == EBCT_MOD ##0 s_ctl_quiet;
    endsequence

    sequence s_cc1_set;
        st.tmr[0].upd && st.tmr[0].cnt == st.tmr[0].cc1
        && st.tmr[0].oc[1] && st.tmr[0].cmp[5:3] == ACT_SET;
    endsequence

    a_mod_count: assert property (
        s_mod_step ##0 (st.tmr[0].cnt != st.tmr[0].cc0_act)
        |=> st.tmr[0].cnt == 8'($past(st.tmr[0].cnt) + CNT_ONE))
        else $error("modulo count did not step up");

    a_mod_wrap: assert property (
        s_mod_step ##0 (st.tmr[0].cnt == st.tmr[0].cc0_act)
        |=> st.tmr[0].cnt == CNT_ZERO ##1 st.tmr[0].flags[0])
        else $error("modulo wrap or terminal flag missing");

    a_down_hold: assert property (
        st.tmr[0].mode == EBCT_DOWN && st.tmr[0].cnt == CNT_ZERO
        && !st.tmr[0].armed && !sfr_wr
        |=> st.tmr[0].cnt == CNT_ZERO)
        else $error("down counter left zero");

    a_down_flag: assert property (
        st.tmr[0].mode == EBCT_DOWN && st.tmr[0].upd
        && st.tmr[0].cnt == CNT_ZERO && st.tmr[0].moved_down
        |=> st.tmr[0].flags[0])
        else $error("down terminal flag missing");

    a_updn_flags: assert property (
        st.tmr[0].mode == EBCT_UPDN && st.tmr[0].upd
        && st.tmr[0].cnt == CNT_ZERO && st.tmr[0].moved_down
        |=> st.tmr[0].flags[1:0] == 2'h3)
        else $error("up/down zero flags missing");

    a_halt_hold: assert property (
        !st.tmr[0].start ##0 s_ctl_quiet |=> $stable(st.tmr[0].cnt))
        else $error("halted counter moved");

    a_cc1_now: assert property (
        sfr_wr && sfr_addr == TA_BASE + OFS_CC1
        |=> st.tmr[0].cc1 == $past(sfr_wdata))
        else $error("channel one compare not immediate");

    a_cc0_wait: assert property (
        st.tmr[0].cnt != CNT_ZERO |=> $stable(st.tmr[0].cc0_act))
        else $error("channel zero compare changed off zero");

    a_pin_set: assert property (
        s_cc1_set |=> chan_out[1])
        else $error("compare set action missed");

    a_irq_mask: assert property (
        st.tmr[0].flags[0] && st.tmr[0].terminal_count_irq_mask
        && timer_interrupt_enable[0]
        |=> cpu_timer_interrupt_flag[0]
        ##1 timer_irq[0] == $past(timer_interrupt_enable[0]))
        else $error("masked terminal event gave no request");

    a_read_count: assert property (
        sfr_addr == TA_BASE + OFS_CNT
        |=> sfr_rdata == $past(st.tmr[0].cnt))
        else $error("counter readback wrong");

endmodule
`default_nettype wire

// ==== verification/ebct_host_model.sv ====
// Far-side model: the CPU tick source and the DMA trigger counters.
// Assumes the timer samples timer_tick on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ebct_host_model (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            resetn,
    // Tick source
    input  wire logic            slow,
    output logic                 timer_tick,
    // DMA triggers, a0 a1 b0 b1
    input  wire logic [3:0]      dma_trig,
    output logic [3:0][7:0]      dma_cnt
);
    // ------------------------------------------------------------------
    // Tick every cycle, or every other cycle when slow
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            timer_tick <= 1'b0;
            dma_cnt    <= '0;
        end
        else
        begin
            timer_tick <= slow ? ~timer_tick : 1'b1;
            for (int i = 0; i < 4; i++)
                if (dma_trig[i])
                    dma_cnt[i] <= dma_cnt[i] + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== verification/ebct_top_test.sv ====
// Self-checking bench for the dual 8-bit compare timer.
// Assumes the host model supplies the tick and counts DMA pulses.
`timescale 1ns/1ps
`default_nettype none
module ebct_top_test;
    logic             clock = 1'b0;
    logic             resetn;
    logic      [7:0]  sfr_addr;
    logic             sfr_wr;
    logic      [7:0]  sfr_wdata;
    logic      [7:0]  sfr_rdata;
    logic      [1:0]  ien;
    logic      [1:0]  cif;
    logic      [1:0]  irq;
    logic      [3:0]  dma;
    logic      [3:0]  chan_out;
    logic      [3:0]  chan_oe;
    logic             slow;
    logic             tick;
    logic [3:0][7:0]  dma_cnt;
    logic      [7:0]  v [16];
    logic      [15:0] pv;
    int               err_count = 0;
    int               n_compared = 0;
    // Reset-value rows: address beside expected read data
    logic [7:0] ra [9] = '{8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE, 8'hCF,
                           8'hEB, 8'hD8, 8'hC0};
    logic [7:0] re [9] = '{8'h00, 8'h08, 8'h40, 8'h00, 8'h40, 8'h00,
                           8'h08, 8'h00, 8'h00};
    logic [7:0] pat [4] = '{8'h00, 8'h01, 8'h02, 8'h01};

    always #25 clock = ~clock;

    ebct_top i_dut (
        .clock                    (clock),
        .resetn                   (resetn),
        .timer_tick               (tick),
        .sfr_addr                 (sfr_addr),
        .sfr_wr                   (sfr_wr),
        .sfr_wdata                (sfr_wdata),
        .sfr_rdata                (sfr_rdata),
        .timer_interrupt_enable   (ien),
        .cpu_timer_interrupt_flag (cif),
        .timer_irq                (irq),
        .dma_trig_a_chan0         (dma[0]),
        .dma_trig_a_chan1         (dma[1]),
        .dma_trig_b_chan0         (dma[2]),
        .dma_trig_b_chan1         (dma[3]),
        .chan_out                 (chan_out),
        .chan_oe                  (chan_oe)
    );

    ebct_host_model i_host (
        .clock      (clock),
        .resetn     (resetn),
        .slow       (slow),
        .timer_tick (tick),
        .dma_trig   (dma),
        .dma_cnt    (dma_cnt)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wr = 1'b1;
        sfr_wdata = d;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask

    // Read data lags the address by one cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        @(negedge clock);
        d = sfr_rdata;
    endtask

    // Count and channel-one pin, sampled together every cycle
    task automatic seq();
        @(negedge clock);
        sfr_addr = 8'hCA;
        for (int i = 0; i < 16; i++)
        begin
            @(negedge clock);
            v[i] = sfr_rdata;
            pv[i] = chan_out[1];
        end
    endtask

    function automatic int find(input logic [7:0] x, input int s);
        for (int i = s; i < 9; i++)
            if (v[i] === x)
                return i;
        return 0;
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int         k;
        logic [7:0] r;
        logic [7:0] d0;
        resetn = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        ien = 2'b01;
        slow = 1'b0;
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            rd(ra[i], r);
            check(r, re[i]);
        end
        wr(8'hCA, 8'h55);
        rd(8'hCA, r);
        check(r, 8'h00);
        // Modulo, period of four
        wr(8'hCD, 8'h03);
        wr(8'hCB, 8'h1A);
        seq();
        for (int i = 0; i < 15; i++)
            check(v[i+1], v[i] == 8'h03 ? 8'h00 : v[i] + 8'h01);
        rd(8'hD8, r);
        check(r & 8'h01, 8'h01);
        check(cif[0], 1'b1);
        // Flags set with every mask off, then unmasked while halted
        wr(8'hCB, 8'h02);
        wr(8'hCC, 8'h00);
        wr(8'hCE, 8'h00);
        wr(8'hD8, 8'h00);
        wr(8'hCB, 8'h12);
        repeat (8) @(negedge clock);
        wr(8'hCB, 8'h02);
        rd(8'hD8, r);
        check(r & 8'h07, 8'h07);
        check(cif[0], 1'b0);
        wr(8'hCB, 8'h0A);
        repeat (2) @(negedge clock);
        check(cif[0], 1'b1);
        check(irq[0], 1'b1);
        ien = 2'b00;
        repeat (2) @(negedge clock);
        check(irq[0], 1'b0);
        // Down from five, then hold
        wr(8'hCB, 8'h04);
        wr(8'hD8, 8'h00);
        wr(8'hCD, 8'h05);
        wr(8'hCB, 8'h19);
        seq();
        k = find(8'h05, 0);
        for (int i = 0; i < 6; i++)
            check(v[k+i], 8'(5 - i));
        check(v[15], 8'h00);
        rd(8'hD8, r);
        check(r & 8'h01, 8'h01);
        // Up/down between zero and two
        wr(8'hCB, 8'h04);
        wr(8'hD8, 8'h00);
        wr(8'hCD, 8'h02);
        wr(8'hCB, 8'h13);
        seq();
        k = find(8'h00, 0);
        for (int i = 0; i < 8; i++)
            check(v[k+i], pat[i%4]);
        rd(8'hD8, r);
        check(r & 8'h03, 8'h03);
        // Every compare action on timer A channel one
        for (int a = 0; a < 5; a++)
        begin
            wr(8'hCB, 8'h04);
            wr(8'hCE, 8'(a * 8 + 4));
            wr(8'hCF, 8'h01);
            wr(8'hCB, 8'h12);
            d0 = dma_cnt[1];
            seq();
            k = find(8'h01, 1);
            check(pv[k], a == 2 ? !pv[k-1] : (a == 0 || a == 3));
            if (a > 2)
                check(pv[k+2], a == 4);
            check(chan_oe[1], 1'b1);
            check(dma_cnt[1] != d0, 1'b1);
        end
        // Divide by eight on a half-rate tick, then halt
        slow = 1'b1;
        wr(8'hCB, 8'h04);
        wr(8'hCB, 8'h70);
        repeat (40) @(negedge clock);
        wr(8'hCB, 8'h60);
        rd(8'hCA, r);
        check(r >= 8'h01 && r <= 8'h04, 1'b1);
        rd(8'hCA, d0);
        check(d0, r);
        // Second instance counts on its own
        wr(8'hEB, 8'h10);
        repeat (5) @(negedge clock);
        rd(8'hEA, r);
        check(r != 8'h00, 1'b1);
        check({3'h0, chan_oe[3:2], chan_out[0], irq[1], cif[1]}, 8'h00);
        stop_test();
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        err_count++;
        $display("[FAIL] %0t run did not finish in time", $time);
        stop_test();
    end
endmodule
`default_nettype wire
